/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uers_regs.svh"
module tb
   import uers_pkg::*;
;
   logic mclk, rst, rxLine, rxPop, holdPop;
   logic [15:0] baudDivisor;
   uers_mode_t serialMode;
   logic [8:0] rxData;
   logic rxDataAvailable, framingErrorFlag, parityErrorFlag, receiverIdleFlag, rxOverrun;
   uers_entry_t expQ[$];
   uers_entry_t exp;
   int errors, n_checks, popWait;
   logic [16:0] lfsr;
   ////////////////////////////////////////////////////////////////////////////////
   // The receiver under test and the transmitter facing it.
   uers_rx #(.FIFO_DEPTH(4), .FIFO_AW(2)) uers_rx_i (.mclk(mclk), .rst(rst), .rxLine(rxLine),
      .baudDivisor(baudDivisor), .serialMode(serialMode), .rxPop(rxPop), .rxData(rxData),
      .rxDataAvailable(rxDataAvailable), .framingErrorFlag(framingErrorFlag),
      .parityErrorFlag(parityErrorFlag), .receiverIdleFlag(receiverIdleFlag),
      .rxOverrun(rxOverrun));
   uers_tx_model #(.BIT_CLKS(16)) tx_i (.mclk(mclk), .rxLine(rxLine));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [16:0] nextRand(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : nextRand
   // Counts one comparison and reports a mismatch at once.
   task automatic check(input logic [11:0] got, input logic [11:0] want);
      n_checks++;
      if (got !== want) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   // Sends one character in the current mode and notes the entry it must leave.
   task automatic frame(input logic [8:0] d, input logic badPar, input logic badStop);
      logic [19:0] b;
      int n;
      logic nine, two, hasPar;
      @(posedge mclk);
      nine = (serialMode.dataParitySelect == `UERS_PD_9N);
      two = serialMode.stopCountSelect;
      hasPar = (serialMode.dataParitySelect == `UERS_PD_8E) ||
               (serialMode.dataParitySelect == `UERS_PD_8O);
      b = '0;
      n = 1;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         b[n] = d[i];
         n++;
      end
      if (hasPar) begin
         b[n] = (^d[7:0]) ^ badPar ^ (serialMode.dataParitySelect == `UERS_PD_8O);
         n++;
      end
      b[n] = !(badStop && !two);
      n++;
      if (two) begin
         b[n] = !badStop;
         n++;
      end
      expQ.push_back('{nine ? d : {1'b0, d[7:0]}, badStop, badPar && hasPar && !badStop});
      fork
         tx_i.send(b, n);
         begin
            repeat (48) @(posedge mclk);
            check(receiverIdleFlag, 1'b0);
         end
      join
      repeat (4) @(posedge mclk);
      check(receiverIdleFlag, 1'b1);
      repeat (32) @(posedge mclk);
   endtask : frame
   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 8 ns period.
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Takes the oldest note whenever a word is at the head, holdPop is low and popWait is zero, compares and pops it.
   always @(posedge mclk) begin
      rxPop <= 1'b0;
      if (popWait > 0) begin
         popWait <= popWait - 1;
      end else if (rxDataAvailable === 1'b1 && holdPop === 1'b0) begin
         if (expQ.size() == 0) begin
            check(12'hFFF, 12'h000);
         end else begin
            exp = expQ.pop_front();
            check({rxData, framingErrorFlag, parityErrorFlag, rxOverrun}, {exp, 1'b0});
         end
         rxPop <= 1'b1;
         popWait <= 3;
      end
   end
   // Main sequence.
   initial begin
      rst = 1'b1;
      holdPop = 1'b0;
      baudDivisor = 16'h0000;
      serialMode = '0;
      errors = 0;
      n_checks = 0;
      popWait = 0;
      lfsr = 17'h166ED;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      // Every data/parity mode with both stop counts: clean, bad parity, low stop.
      for (int m = 0; m < 8; m++) begin
         serialMode <= m[2:0];
         for (int k = 0; k < 3; k++) begin
            lfsr = nextRand(lfsr);
            frame(lfsr[8:0], k == 1, k == 2);
         end
      end
      // A long low line becomes one all-zero flagged word; the next character is clean.
      serialMode <= 3'h0;
      @(posedge mclk);
      expQ.push_back('{9'h000, 1'b1, 1'b0});
      fork
         tx_i.send(20'h00000, 20);
         begin
            repeat (224) @(posedge mclk);
            check(receiverIdleFlag, 1'b1);
         end
      join
      repeat (32) @(posedge mclk);
      frame(9'h0A5, 1'b0, 1'b0);
      // A flagged word held at the head is wiped by reset.
      holdPop <= 1'b1;
      frame(9'h03C, 1'b0, 1'b1);
      check({rxDataAvailable, framingErrorFlag}, 2'h3);
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      expQ.delete();
      @(posedge mclk);
      check({rxDataAvailable, framingErrorFlag, parityErrorFlag, receiverIdleFlag}, 4'h1);
      holdPop <= 1'b0;
      frame(9'h05A, 1'b0, 1'b0);
      for (int t = 0; t < 400 && expQ.size() > 0; t++)
         @(posedge mclk);
      check(12'(expQ.size()), 12'h000);
      wrap_up();
   end
endmodule : tb
`default_nettype wire

/* File: verification/uers_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Remote transmitter on the receive line; the line rests high between characters.
module uers_tx_model #(
   parameter int BIT_CLKS = 16
) (
   input wire logic mclk, // Clock.
   output logic rxLine // Serial line towards the receiver.
);
   // The line idles high from time zero.
   initial rxLine = 1'b1;
   // Sends n bits LSB first, one bit time each, then releases the line high.
   task automatic send(input logic [19:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         rxLine <= bits[i];
         repeat (BIT_CLKS) @(posedge mclk);
      end
      rxLine <= 1'b1;
   endtask : send
endmodule : uers_tx_model
`default_nettype wire

/* File: verilog/uers_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module uers_fifo
   import uers_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic mclk, // Clock.
   input wire logic rst, // Synchronous reset.
   input wire logic wrEn, // Push strobe.
   input var uers_entry_t wrData, // Entry to push.
   input wire logic rdEn, // Pop strobe.
   output uers_entry_t headData, // Entry at the head.
   output logic notEmpty, // Any entry held.
   output logic full // No room left.
);
   uers_entry_t mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic doWr;
   logic doRd;

   // Accept pushes only while there is room; pops only while data exists.
   assign doWr = wrEn && !full;
   assign doRd = rdEn && notEmpty;
   assign notEmpty = (count_q != '0);
   assign full = (count_q == (AW+1)'(DEPTH));
   assign headData = mem[rdPtr_q];

   // Storage array write.
   always_ff @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr_q] <= wrData;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doWr) wrPtr_q <= wrPtr_q + 1'b1;
         if (doRd) rdPtr_q <= rdPtr_q + 1'b1;
         if (doWr && !doRd) count_q <= count_q + 1'b1;
         else if (doRd && !doWr) count_q <= count_q - 1'b1;
      end
   end
endmodule : uers_fifo
`default_nettype wire

/* File: verilog/uers_pkg.sv */
package uers_pkg;
   // One receive FIFO entry: data with its stored error bits.
   typedef struct packed {
      logic [8:0] data;
      logic framingErr;
      logic parityErr;
   } uers_entry_t;
   // Receiver mode configuration.
   typedef struct packed {
      logic [1:0] dataParitySelect;
      logic stopCountSelect;
   } uers_mode_t;
endpackage : uers_pkg

/* File: verilog/uers_regs.svh */
`ifndef UERS_REGS_SVH
`define UERS_REGS_SVH
// Field positions inside the mode word.
`define UERS_MODE_STOP_BIT 0
`define UERS_MODE_PDSEL_LO 1
`define UERS_MODE_PDSEL_HI 2
// Data/parity select encodings.
`define UERS_PD_8N 2'h0
`define UERS_PD_8E 2'h1
`define UERS_PD_8O 2'h2
`define UERS_PD_9N 2'h3
// Timing counts.
`define UERS_OVERSAMPLE 16
`define UERS_MID_SAMPLE 7
`define UERS_BREAK_BITS 13
// Reset values.
`define UERS_RST_DIV 16'h0000
`endif

/* File: verilog/uers_rx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uers_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - Low stop bit sets framing error.
// R2 - Two stop bits: either low flags error.
// R3 - Framing error read-only, buffered, cleared by reset.
// R4 - Parity error only when parity enabled.
// R5 - Parity error read-only, buffered, reset cleared.
// R6 - Idle reads 0 from start to stop.
// R7 - Idle reads 1 between stop and start.
// R8 - Bit count set by mode fields.
// R9 - Long break ends character, flags, loads zeros.
// R10 - After break, wait for high line.
// R11 - Break stored as zeros with framing error.
// R12 - No reception until high stop level.
// R13 - Idle high while still awaiting stop level.
// R14 - Flags show head entry's error bits.
module uers_rx
   import uers_pkg::*;
#(
   parameter int FIFO_DEPTH = 4,
   parameter int FIFO_AW = 2
) (
   input wire logic mclk, // 125 MHz clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic rxLine, // Serial receive line.
   input wire logic [15:0] baudDivisor, // Oversample divisor minus one.
   input var uers_mode_t serialMode, // Data/parity and stop count select.
   input wire logic rxPop, // Software read of the head word.
   output logic [8:0] rxData, // Head word data.
   output logic rxDataAvailable, // FIFO holds a word.
   output logic framingErrorFlag, // Head word framing error.
   output logic parityErrorFlag, // Head word parity error.
   output logic receiverIdleFlag, // Receiver idle.
   output logic rxOverrun // Word lost to a full FIFO.
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_START = 6'b000010,
      S_DATA = 6'b000100,
      S_PAR = 6'b001000,
      S_STOP = 6'b010000,
      S_WAITHI = 6'b100000
   } uers_state_t;

   uers_state_t state_q;
   logic [15:0] divCnt_q;
   logic tick;
   logic [3:0] subCnt_q;
   logic [3:0] bitCnt_q;
   logic [8:0] shift_q;
   logic parBit_q;
   logic frameErr_q;
   logic stopIdx_q;
   logic allZero_q;
   logic sampleNow;
   logic bitEnd;
   logic [3:0] dataBits;
   logic parityOn;
   logic evenSel;
   logic parityBad;
   logic pushEn;
   uers_entry_t pushEntry;
   uers_entry_t head;
   logic notEmpty;
   logic fifoFull;
   logic [4:0] lowBits_q;
   // Checking aids for the character length.
   logic [3:0] charBits_q;
   logic [3:0] charBitsWant;

   ////////////////////////////////////////////////////////////////////////////
   // Character shape decoded from the mode fields.
   // Nine-bit mode has no parity; the parity modes carry eight data bits.
   assign dataBits = (serialMode.dataParitySelect == `UERS_PD_9N) ? 4'h9 : 4'h8; // [R8]
   assign parityOn = (serialMode.dataParitySelect == `UERS_PD_8E) ||
                     (serialMode.dataParitySelect == `UERS_PD_8O);
   assign evenSel = (serialMode.dataParitySelect == `UERS_PD_8E);
   // Even parity: total ones with parity bit is even.
   // Eight data bits sit in the upper bits of the shift register once all are in.
   assign parityBad = parityOn && ((^shift_q[8:1] ^ parBit_q) != !evenSel); // [R4]
   assign sampleNow = tick && (subCnt_q == 4'(`UERS_MID_SAMPLE));
   assign bitEnd = tick && (subCnt_q == 4'(`UERS_OVERSAMPLE - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Oversample divider: one-cycle enable at sixteen times the bit rate.
   // A divisor of zero gives a tick on every clock.
   always_ff @(posedge mclk) begin
      if (rst) begin
         divCnt_q <= `UERS_RST_DIV;
         tick <= 1'b0;
      end else if (divCnt_q >= baudDivisor) begin
         divCnt_q <= 16'h0000;
         tick <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Receive sequencer.
   // A start is taken on a tick with the line low; a high line at mid start drops it.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= S_IDLE;
         subCnt_q <= 4'h0;
         bitCnt_q <= 4'h0;
         shift_q <= 9'h000;
         parBit_q <= 1'b0;
         frameErr_q <= 1'b0;
         stopIdx_q <= 1'b0;
         allZero_q <= 1'b1;
         pushEn <= 1'b0;
         pushEntry <= '0;
      end else begin
         pushEn <= 1'b0;
         if (tick) subCnt_q <= subCnt_q + 4'h1;
         case (state_q)
            S_IDLE: begin
               subCnt_q <= 4'h0;
               if (tick && !rxLine) begin
                  state_q <= S_START;
                  subCnt_q <= 4'h1;
               end
            end
            S_START: begin
               if (sampleNow && rxLine) state_q <= S_IDLE;
               if (bitEnd) begin
                  state_q <= S_DATA;
                  bitCnt_q <= 4'h0;
                  frameErr_q <= 1'b0;
                  stopIdx_q <= 1'b0;
                  allZero_q <= 1'b1;
               end
            end
            S_DATA: begin
               if (sampleNow) begin
                  shift_q <= {rxLine, shift_q[8:1]};
                  if (rxLine) allZero_q <= 1'b0;
               end
               if (bitEnd) begin
                  bitCnt_q <= bitCnt_q + 4'h1;
                  if (bitCnt_q == dataBits - 4'h1) begin // [R8]
                     state_q <= parityOn ? S_PAR : S_STOP;
                  end
               end
            end
            S_PAR: begin
               if (sampleNow) begin
                  parBit_q <= rxLine;
                  if (rxLine) allZero_q <= 1'b0;
               end
               if (bitEnd) state_q <= S_STOP;
            end
            S_STOP: begin
               if (sampleNow && !rxLine) frameErr_q <= 1'b1; // [R1] [R2]
               if (bitEnd) begin
                  if (serialMode.stopCountSelect && !stopIdx_q) begin
                     stopIdx_q <= 1'b1; // [R2]
                  end else begin
                     pushEn <= 1'b1;
                     pushEntry.data <= (dataBits == 4'h9) ? shift_q : {1'b0, shift_q[8:1]};
                     pushEntry.framingErr <= frameErr_q; // [R3]
                     pushEntry.parityErr <= parityBad && !frameErr_q; // [R5]
                     // A character that ends low with all bits zero is a break.
                     if (frameErr_q && allZero_q) begin
                        pushEntry.data <= 9'h000; // [R11] [R9]
                        pushEntry.parityErr <= 1'b0;
                     end
                     state_q <= frameErr_q ? S_WAITHI : S_IDLE; // [R10]
                  end
               end
            end
            S_WAITHI: begin
               // The bit-time counter runs on here so a long low keeps being measured.
               if (tick && rxLine) state_q <= S_IDLE; // [R12]
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Low-line duration in bit times, for observing long breaks.
   // It saturates, so a line held low for ever cannot wrap back to a short count.
   always_ff @(posedge mclk) begin
      if (rst || rxLine) lowBits_q <= 5'h00;
      else if (bitEnd && lowBits_q != 5'h1F) lowBits_q <= lowBits_q + 5'h01;
   end

   // Bit times since the start bit, counted apart from the sequencer's data counter
   // so that a character of the wrong length shows at the push. Idle clears it.
   assign charBitsWant = 4'h2 + dataBits + {3'h0, parityOn} +
                         {3'h0, serialMode.stopCountSelect}; // [R8]
   always_ff @(posedge mclk) begin
      if (rst || state_q == S_IDLE) charBits_q <= 4'h0;
      else if (bitEnd && charBits_q != 4'hF) charBits_q <= charBits_q + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer holding data with its error bits.
   // A push into a full buffer drops the word and sets the sticky overrun flag.
   // Pops on an empty buffer are ignored inside the buffer itself.
   uers_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .wrEn(pushEn),
      .wrData(pushEntry),
      .rdEn(rxPop),
      .headData(head),
      .notEmpty(notEmpty),
      .full(fifoFull)
   );

   // Registered status outputs reflecting the head entry.
   // Both error flags come from the same entry as the data, so they always travel together.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxData <= 9'h000;
         rxDataAvailable <= 1'b0;
         framingErrorFlag <= 1'b0; // [R3]
         parityErrorFlag <= 1'b0; // [R5]
         rxOverrun <= 1'b0;
      end else begin
         rxData <= notEmpty ? head.data : 9'h000;
         rxDataAvailable <= notEmpty; // [R9]
         framingErrorFlag <= notEmpty && head.framingErr; // [R14]
         parityErrorFlag <= notEmpty && head.parityErr; // [R14]
         if (pushEn && fifoFull) rxOverrun <= 1'b1;
      end
   end

   // Idle is low only while a character is in progress; waiting state counts as idle.
   // It is registered so that the output comes straight from a flip-flop.
   always_ff @(posedge mclk) begin
      if (rst) receiverIdleFlag <= 1'b1;
      else receiverIdleFlag <= (state_q == S_IDLE) || (state_q == S_WAITHI); // [R6] [R7] [R13]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle flag follows the sequencer one cycle later.
   // The checks below watch what this module drives and its rxLine and serialMode inputs.
   AST_IDLE_LOW: assert property (@(posedge mclk) disable iff (rst) // [R6]
      (state_q == S_DATA) |=> !receiverIdleFlag) else $error("Idle high mid-character.");
   AST_IDLE_START: assert property (@(posedge mclk) disable iff (rst) // [R6]
      (state_q == S_START) |=> !receiverIdleFlag) else $error("Idle high in start bit.");
   AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (rst) // [R7]
      (state_q == S_IDLE) |=> receiverIdleFlag) else $error("Idle low while idle.");
   AST_WAIT_IDLE: assert property (@(posedge mclk) disable iff (rst) // [R13]
      (state_q == S_WAITHI) |=> receiverIdleFlag) else $error("Idle low after break.");

   // After a break the low line must not start a character, and nothing is stored.
   AST_NO_START_IN_WAIT: assert property (@(posedge mclk) disable iff (rst) // [R10]
      (state_q == S_WAITHI && !rxLine) |=> state_q == S_WAITHI)
      else $error("Left break wait while line low.");
   AST_WAIT_EXIT: assert property (@(posedge mclk) disable iff (rst) // [R12]
      (state_q == S_WAITHI) |=> (state_q == S_WAITHI || state_q == S_IDLE))
      else $error("Reception resumed without stop level.");
   AST_NO_PUSH_IN_WAIT: assert property (@(posedge mclk) disable iff (rst) // [R12]
      (state_q == S_WAITHI && $past(state_q == S_WAITHI)) |-> !pushEn)
      else $error("Word stored while waiting for stop level.");
   AST_LONG_BREAK: assert property (@(posedge mclk) disable iff (rst) // [R9]
      (lowBits_q > 5'(`UERS_BREAK_BITS)) |-> (state_q == S_WAITHI && receiverIdleFlag))
      else $error("Long low line not ended as a break.");

   // Stored entries carry the right error bits and the right character length.
   AST_FE_STORED: assert property (@(posedge mclk) disable iff (rst) // [R1]
      (state_q == S_STOP && bitEnd && frameErr_q && !(serialMode.stopCountSelect && !stopIdx_q))
      |=> pushEn && pushEntry.framingErr) else $error("Framing error not stored.");
   AST_LOW_STOP: assert property (@(posedge mclk) disable iff (rst) // [R2]
      (state_q == S_STOP && sampleNow && !rxLine) |=> frameErr_q)
      else $error("Low stop not flagged.");
   AST_BREAK_ZERO: assert property (@(posedge mclk) disable iff (rst) // [R11]
      (pushEn && pushEntry.framingErr && allZero_q) |-> pushEntry.data == 9'h000)
      else $error("Break not stored as zero.");
   AST_NOPAR: assert property (@(posedge mclk) disable iff (rst) // [R4]
      (pushEn && !$past(parityOn)) |-> !pushEntry.parityErr)
      else $error("Parity error without parity mode.");
   AST_PAR_MATCH: assert property (@(posedge mclk) disable iff (rst) // [R4]
      (pushEn && !pushEntry.framingErr && $past(parityOn))
      |-> pushEntry.parityErr == ((^pushEntry.data[7:0] ^ parBit_q) != $past(!evenSel)))
      else $error("Parity error does not match the stored word.");
   AST_CHAR_LEN: assert property (@(posedge mclk) disable iff (rst) // [R8]
      pushEn |-> charBits_q == charBitsWant) else $error("Wrong character length.");

   // Status outputs mirror the head of the buffer and clear with it.
   AST_HEAD_FLAGS: assert property (@(posedge mclk) disable iff (rst) // [R14]
      notEmpty |=> framingErrorFlag == $past(head.framingErr))
      else $error("Status not from head entry.");
   AST_RESET_CLR: assert property (@(posedge mclk) rst |=> !framingErrorFlag && !parityErrorFlag) // [R3]
      else $error("Flags not cleared by reset.");
   AST_EMPTY_CLR: assert property (@(posedge mclk) disable iff (rst) // [R5]
      !notEmpty |=> !parityErrorFlag) else $error("Parity flag without data.");
   AST_AVAIL: assert property (@(posedge mclk) disable iff (rst) // [R9]
      notEmpty |=> rxDataAvailable) else $error("Stored word not shown as available.");

   // Main scenarios worth seeing at least once.
   COV_BREAK: cover property (@(posedge mclk) disable iff (rst) state_q == S_WAITHI);
   COV_LONG_LOW: cover property (@(posedge mclk) disable iff (rst) // [R9]
      lowBits_q > 5'(`UERS_BREAK_BITS));
   COV_PARERR: cover property (@(posedge mclk) disable iff (rst) pushEn && pushEntry.parityErr);
   COV_TWO_STOP: cover property (@(posedge mclk) disable iff (rst) stopIdx_q && pushEn);
   COV_NINE_TWO: cover property (@(posedge mclk) disable iff (rst) // [R8]
      pushEn && charBits_q == 4'hC);
endmodule : uers_rx
`default_nettype wire
